// ==== shared/csl_map.svh ====
// Register map, field positions, reset values and timing counts of the clock setup loader.
`ifndef CSL_MAP_SVH
`define CSL_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define CSL_OFF_CTRL        32'h0000_0000
`define CSL_OFF_CMD         32'h0000_0004
`define CSL_OFF_STATUS      32'h0000_0008

// ==========================================================================
// Field positions
`define CSL_CTRL_PROF_LSB   0
`define CSL_CTRL_MASK_LSB   2
`define CSL_CMD_RESTART     0
`define CSL_ST_DONE         0
`define CSL_ST_BUSY         1
`define CSL_ST_NACK         2
`define CSL_ST_INDEX_LSB    8

// ==========================================================================
// Reset values
`define CSL_RST_PROFILE     2'h0
`define CSL_RST_MASK        6'h00

// ==========================================================================
// Profiles and output mask bits
`define CSL_PROFILE_0       2'h0
`define CSL_PROFILE_1       2'h1
`define CSL_PROFILE_2       2'h2
`define CSL_OFF_MEZZ_A      0
`define CSL_OFF_MEZZ_D      1
`define CSL_OFF_SATA_HOST   2
`define CSL_OFF_SATA_DEV    3
`define CSL_OFF_PCIE        4
`define CSL_OFF_DDR3        5

// ==========================================================================
// Table coding
`define CSL_WAIT_MARK       16'hFFFF
`define CSL_FIRST_DELAY     32'hFFFF_0320
`define CSL_LAST_INDEX      5'h1A
`define CSL_MEZZ_DIV_REG    16'h0006
`define CSL_MEZZ_DIV_P0     16'h0005
`define CSL_MEZZ_DIV_P1     16'h0004
`define CSL_MEZZ_DIV_P2     16'h0003
`define CSL_PWRDN_A         16'h0040
`define CSL_PWRDN_B         16'h0080

// ==========================================================================
// Timing
`define CSL_CLK_FREQ_KHZ    200000
`define CSL_SCL_FREQ_KHZ    20
`define CSL_SCL_QUARTER_CYC (`CSL_CLK_FREQ_KHZ / (`CSL_SCL_FREQ_KHZ * 4))

`endif

// ==== shared/csl_pkg.sv ====
// Types shared by the clock setup loader.
package csl_pkg;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    CSL_IDLE,
    CSL_FETCH,
    CSL_WAIT,
    CSL_START,
    CSL_BIT,
    CSL_STOP
  } csl_state_t;

endpackage

// ==== verilog/csl_loader.sv ====
// Power-up setup loader that writes a register table to a clock generator over I2C.
//
// Overview of operation
// [RQ1] Runs on clk, synchronous active-low reset.
// [RQ2] Done output low while loading, high after.
// [RQ3] Two-bit profile selects one of three tables.
// [RQ4] Profiles set mezzanine outputs 100/125/150 MHz.
// [RQ5] Six-bit mask powers down individual outputs.
// [RQ6] Reset rising edge reruns with new settings; the code reruns with CTRL back at reset values (profile 0, no outputs masked).
// [RQ7] First step waits 0x0320 serial clock periods.
// [RQ8] Controller drives SCL, open-drain SDA with acks.
// [RQ9] Entry: register in upper half, value lower.
`timescale 1ns/100ps
`include "csl_map.svh"

module csl_loader
  import csl_pkg::*;
#(
  parameter int QUARTER_CYCLES = `CSL_SCL_QUARTER_CYC,
  parameter logic [6:0] DEV_ADDR = 7'h54  // Arbitrary target address.
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // I2C link
  output logic             scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Status
  output logic             setup_done
);

  // ==========================================================================
  // Table
  function automatic logic [31:0] base_entry(input logic [4:0] idx);
    case (idx)
      5'h00: base_entry = `CSL_FIRST_DELAY;
      5'h01: base_entry = 32'h0003_0000;
      5'h02: base_entry = 32'hFFFF_007D;
      5'h03: base_entry = 32'h0003_0040;
      5'h04: base_entry = 32'hFFFF_007D;
      5'h05: base_entry = 32'h0000_01B9;
      5'h06: base_entry = 32'h0001_0000;
      5'h07: base_entry = 32'h0002_0017;
      5'h08: base_entry = 32'h0003_00F5;
      5'h09: base_entry = 32'h0004_30EB;
      5'h0A: base_entry = 32'h0005_0001;
      5'h0B: base_entry = 32'h0006_0005;
      5'h0C: base_entry = 32'h0007_0001;
      5'h0D: base_entry = 32'h0008_0005;
      5'h0E: base_entry = 32'h0009_0001;
      5'h0F: base_entry = 32'h000A_0030;
      5'h10: base_entry = 32'h000B_0000;
      5'h11: base_entry = 32'h000C_0001;
      5'h12: base_entry = 32'h000D_0030;
      5'h13: base_entry = 32'h000E_0000;
      5'h14: base_entry = 32'h000F_0201;
      5'h15: base_entry = 32'h0010_0014;
      5'h16: base_entry = 32'h0011_0000;
      5'h17: base_entry = 32'h0012_0001;
      5'h18: base_entry = 32'h0013_0000;
      5'h19: base_entry = 32'h0014_0000;
      default: base_entry = 32'hFFFF_007D;
    endcase
  endfunction

  function automatic logic [15:0] mezz_div(input logic [1:0] prof);
    if (prof == `CSL_PROFILE_1) begin
      mezz_div = `CSL_MEZZ_DIV_P1;
    end else if (prof == `CSL_PROFILE_2) begin
      mezz_div = `CSL_MEZZ_DIV_P2;
    end else begin
      mezz_div = `CSL_MEZZ_DIV_P0;
    end
  endfunction

  // Power-down bits that the mask adds to each output's control register.
  function automatic logic [15:0] off_bits(input logic [15:0] reg_a, input logic [5:0] m);
    off_bits = 16'h0000;
    if (reg_a == 16'h0005 && m[`CSL_OFF_MEZZ_A]) off_bits = `CSL_PWRDN_A;
    if (reg_a == 16'h0007 && m[`CSL_OFF_MEZZ_D]) off_bits = `CSL_PWRDN_A;
    if (reg_a == 16'h0009 && m[`CSL_OFF_SATA_HOST]) off_bits = `CSL_PWRDN_A;
    if (reg_a == 16'h000C && m[`CSL_OFF_SATA_DEV]) off_bits = `CSL_PWRDN_A;
    if (reg_a == 16'h000F) begin
      off_bits = (m[`CSL_OFF_PCIE] ? `CSL_PWRDN_A : 16'h0000) | (m[`CSL_OFF_DDR3] ? `CSL_PWRDN_B : 16'h0000);
    end
  endfunction

  // ==========================================================================
  // Registers and bus
  logic [1:0]  profile;
  logic [5:0]  off_mask;
  logic        restart;
  logic        nack_seen;
  logic [4:0]  index;
  csl_state_t  state;
  logic        wr_pend;
  logic [3:0]  wr_sel;
  logic [31:0] cur_entry;
  logic        addr_ok;

  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign restart   = wr_pend && wr_sel[1] && hwdata[`CSL_CMD_RESTART];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_sel  <= 4'h0;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_sel  <= 4'h0;
      if (haddr == `CSL_OFF_CTRL) begin
        wr_sel <= 4'h1;
      end else if (haddr == `CSL_OFF_CMD) begin
        wr_sel <= 4'h2;
      end else if (haddr == `CSL_OFF_STATUS) begin
        wr_sel <= 4'h4;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= 32'h0000_0000;
        if (haddr == `CSL_OFF_CTRL) begin
          hrdata <= {24'h00_0000, off_mask, profile};
        end else if (haddr == `CSL_OFF_STATUS) begin
          hrdata <= {19'h0_0000, index, 5'h00, nack_seen, state != CSL_IDLE, setup_done};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      profile  <= `CSL_RST_PROFILE;
      off_mask <= `CSL_RST_MASK;
    end else if (wr_pend && wr_sel[0]) begin
      profile  <= hwdata[`CSL_CTRL_PROF_LSB +: 2]; // RQ3
      off_mask <= hwdata[`CSL_CTRL_MASK_LSB +: 6]; // RQ5
    end
  end

  // ==========================================================================
  // Sequencer
  logic        sda_meta;
  logic        sda_sync;
  logic [11:0] qcnt;
  logic        tick;
  logic [1:0]  phase;
  logic [15:0] delay_left;
  logic [39:0] frame;
  logic [3:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic        next_scl;
  logic        next_pull;
  logic        last_q;

  always_comb begin
    cur_entry = base_entry(index); // RQ9
    if (cur_entry[31:16] == `CSL_MEZZ_DIV_REG) begin
      cur_entry[15:0] = mezz_div(profile); // RQ4
    end
    cur_entry[15:0] = cur_entry[15:0] | off_bits(cur_entry[31:16], off_mask); // RQ5
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  assign tick   = (qcnt == 12'(QUARTER_CYCLES - 1));
  assign last_q = tick && (phase == 2'h3);

  always_ff @(posedge clk) begin
    if (!rst_b || state == CSL_FETCH) begin
      qcnt <= 12'h000;
    end else begin
      qcnt <= tick ? 12'h000 : qcnt + 12'h001;
    end
  end

  // A rising reset restarts from step 0 with CTRL back at its reset values (profile 0, no outputs masked).
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state      <= CSL_FETCH; // RQ1 RQ6
      index      <= 5'h00;
      phase      <= 2'h0;
      delay_left <= 16'h0000;
      frame      <= 40'h00_0000_0000;
      bit_cnt    <= 4'h0;
      byte_cnt   <= 3'h0;
      setup_done <= 1'b0;
    end else if (restart) begin
      state      <= CSL_FETCH; // RQ6
      index      <= 5'h00;
      setup_done <= 1'b0;
    end else begin
      if (tick) begin
        phase <= phase + 2'h1;
      end
      case (state)
        CSL_FETCH: begin
          phase <= 2'h0;
          if (cur_entry[31:16] == `CSL_WAIT_MARK) begin
            delay_left <= cur_entry[15:0]; // RQ7 RQ9
            state      <= CSL_WAIT;
          end else begin
            frame    <= {DEV_ADDR, 1'b0, cur_entry}; // RQ9
            bit_cnt  <= 4'h0;
            byte_cnt <= 3'h0;
            state    <= CSL_START;
          end
        end
        CSL_WAIT: begin
          if (delay_left == 16'h0000 || (last_q && delay_left == 16'h0001)) begin
            if (index == `CSL_LAST_INDEX) begin
              state      <= CSL_IDLE;
              setup_done <= 1'b1; // RQ2
            end else begin
              index <= index + 5'h01;
              state <= CSL_FETCH;
            end
          end else if (last_q) begin
            delay_left <= delay_left - 16'h0001; // RQ7
          end
        end
        CSL_START: begin
          if (last_q) begin
            state <= CSL_BIT;
          end
        end
        CSL_BIT: begin
          if (last_q) begin
            if (bit_cnt == 4'h8) begin
              bit_cnt  <= 4'h0;
              byte_cnt <= byte_cnt + 3'h1;
              if (byte_cnt == 3'h4) begin
                state <= CSL_STOP;
              end
            end else begin
              frame   <= {frame[38:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        CSL_STOP: begin
          if (last_q) begin
            delay_left <= 16'h0000;
            state      <= CSL_WAIT;
          end
        end
        default: begin
          state <= CSL_IDLE;
        end
      endcase
    end
  end

  // A missing acknowledge is recorded but the table still runs to the end.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nack_seen <= 1'b0;
    end else if (state == CSL_BIT && bit_cnt == 4'h8 && phase == 2'h2 && tick && sda_sync) begin
      nack_seen <= 1'b1; // RQ8
    end else if (wr_pend && wr_sel[2] && hwdata[`CSL_ST_NACK]) begin
      nack_seen <= 1'b0;
    end
  end

  // ==========================================================================
  // Line drive
  always_comb begin
    next_scl  = 1'b1;
    next_pull = 1'b0;
    case (state)
      CSL_START: begin
        next_scl  = (phase < 2'h2);
        next_pull = (phase != 2'h0);
      end
      CSL_BIT: begin
        next_scl  = (phase == 2'h1) || (phase == 2'h2);
        next_pull = (bit_cnt != 4'h8) && !frame[39]; // RQ8
      end
      CSL_STOP: begin
        next_scl  = (phase != 2'h0);
        next_pull = (phase < 2'h2);
      end
      default: begin
        next_scl  = 1'b1;
        next_pull = 1'b0;
      end
    endcase
  end

  assign sda_out = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl    <= 1'b1;
      sda_oe <= 1'b0;
    end else begin
      scl    <= next_scl; // RQ8
      sda_oe <= next_pull;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_fetch_write;
    state == CSL_FETCH && cur_entry[31:16] != `CSL_WAIT_MARK;
  endsequence

  chk_reset_rerun: assert property (!$past(rst_b) |-> state == CSL_FETCH && index == 5'h00 && !setup_done) // RQ1
    else $error("Loader did not restart after reset release.");
  chk_done_at_end: assert property ($rose(setup_done) |-> $past(index) == `CSL_LAST_INDEX && state == CSL_IDLE) // RQ2
    else $error("Done rose before the last table step.");
  chk_done_holds: assert property (setup_done && !restart |=> setup_done) // RQ2
    else $error("Done dropped without a restart.");
  chk_profile_div: assert property (cur_entry[31:16] == `CSL_MEZZ_DIV_REG |-> cur_entry[15:0] == // RQ3 RQ4
    (profile == `CSL_PROFILE_2 ? `CSL_MEZZ_DIV_P2 : (profile == `CSL_PROFILE_1 ? `CSL_MEZZ_DIV_P1 : `CSL_MEZZ_DIV_P0)))
    else $error("Mezzanine divider does not follow the profile.");
  chk_mask_pwrdn: assert property (cur_entry[31:16] == 16'h0005 && off_mask[0] |-> cur_entry[6]) // RQ5
    else $error("Masked mezzanine A output not powered down.");
  chk_restart_run: assert property (restart |=> state == CSL_FETCH && index == 5'h00 && !setup_done) // RQ6
    else $error("Restart command did not rerun the table.");
  chk_first_delay: assert property (state == CSL_FETCH && index == 5'h00 |=> state == CSL_WAIT && delay_left == 16'h0320) // RQ7
    else $error("First step is not the start-up delay.");
  chk_sda_stable: assert property (state == CSL_BIT && $past(state) == CSL_BIT && scl && $past(scl) |-> $stable(sda_oe)) // RQ8
    else $error("SDA moved while SCL was high.");
  chk_entry_frame: assert property (s_fetch_write |=> state == CSL_START && frame[31:0] == $past(cur_entry)) // RQ9
    else $error("Write frame does not carry the table entry.");

endmodule

// ==== verif/csl_target_model.sv ====
// Behavioural I2C clock generator target that acknowledges and records register writes.
`timescale 1ns/100ps
module csl_target_model (
  // I2C wire
  input  wire logic scl,
  input  wire logic sda,
  // Fault control
  input  wire logic nack_addr,
  // Open-drain pull of the shared data wire
  output logic      pull
);
  logic [7:0]  sh;
  logic [7:0]  b [0:4];
  logic [7:0]  addr_byte;
  logic [15:0] wr_val [logic [15:0]];
  int          nbit = 0;
  int          nbyte = 0;
  int          n_writes = 0;

  initial pull = 1'b0;

  // ==========================================================================
  // Framing
  always @(negedge sda) if (scl) begin
    nbit = 0;
    nbyte = 0;
  end
  // Only a full five-byte frame counts as a register write.
  always @(posedge sda) if (scl && nbyte == 5) begin
    addr_byte = b[0];
    wr_val[{b[1], b[2]}] = {b[3], b[4]};
    n_writes++;
    nbyte = 0;
  end

  // ==========================================================================
  // Bits, most significant first, and acknowledge
  always @(posedge scl) begin
    if (nbit < 8) begin
      sh = {sh[6:0], sda};
      nbit++;
      if (nbit == 8 && nbyte < 5) begin
        b[nbyte] = sh;
        nbyte++;
      end
    end else begin
      nbit = 0;
    end
  end
  always @(negedge scl) begin
    pull = (nbit == 8) && !(nack_addr && nbyte == 1);
  end
endmodule

// ==== verif/csl_loader_bench.sv ====
// Self-checking bench for the clock generator setup loader.
`timescale 1ns/100ps
`include "csl_map.svh"
`define CHECK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module csl_loader_bench;
  localparam logic [6:0] DEV = 7'h54;  // Arbitrary target address.
  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        nack_addr;
  logic        hreadyout;
  logic        hresp;
  logic        scl;
  logic        sda_out;
  logic        sda_oe;
  logic        setup_done;
  logic        tgt_pull;
  logic [31:0] hrdata;
  logic [31:0] rd;
  wire         sda = !(sda_oe | tgt_pull);
  int          num_errors = 0;
  int          n_compared = 0;
  int          base;

  csl_loader #(.QUARTER_CYCLES(4), .DEV_ADDR(DEV)) DUT (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .setup_done(setup_done));

  csl_target_model tgt (.scl(scl), .sda(sda), .nack_addr(nack_addr), .pull(tgt_pull));

  // ==========================================================================
  // Bus and wait helpers
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_writes(input int target);
    int n;
    n = 0;
    while (tgt.n_writes < target && n < 30000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (setup_done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    `CHECK("setup_done", 1'b1, setup_done)
  endtask

  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_power_up();
    repeat (5) @(posedge clk);
    `CHECK("scl_in_reset", 1'b1, scl)
    `CHECK("oe_in_reset", 1'b0, sda_oe)
    `CHECK("sda_out", 1'b0, sda_out)
    `CHECK("done_in_reset", 1'b0, setup_done)
    rst_b <= 1'b1;
    bus(1'b1, `CSL_OFF_CTRL, 32'h0000_0001);
    repeat (12700) @(posedge clk);
    `CHECK("writes_in_delay", 0, tgt.n_writes)
    repeat (1000) @(posedge clk);
    `CHECK("writes_after_delay", 1, tgt.n_writes)
    `CHECK("first_reg3", 16'h0000, tgt.wr_val[16'h0003])
    `CHECK("addr_byte", {DEV, 1'b0}, tgt.addr_byte)
  endtask

  task automatic t_profile1_run();
    wait_done();
    `CHECK("write_count", 23, tgt.n_writes)
    `CHECK("reg6_p1", 16'h0004, tgt.wr_val[16'h0006])
    `CHECK("reg5_p1", 16'h0001, tgt.wr_val[16'h0005])
    `CHECK("reg15_p1", 16'h0201, tgt.wr_val[16'h000F])
    bus(1'b0, `CSL_OFF_STATUS, 32'h0);
    `CHECK("status_done", 32'h0000_1A01, rd)
    `CHECK("hresp", 1'b0, hresp)
    bus(1'b0, 32'h0000_0010, 32'h0);
    `CHECK("unmapped", 32'h0, rd)
  endtask

  task automatic t_restart_mask();
    // Profile 2 with mezzanine A and DDR3 turned off.
    bus(1'b1, `CSL_OFF_CTRL, 32'h0000_0086);
    bus(1'b1, `CSL_OFF_CMD, 32'h0000_0001);
    base = tgt.n_writes;
    repeat (2) @(posedge clk);
    `CHECK("done_restart", 1'b0, setup_done)
    wait_done();
    `CHECK("write_count2", base + 23, tgt.n_writes)
    `CHECK("reg6_p2", 16'h0003, tgt.wr_val[16'h0006])
    `CHECK("reg5_mask", 16'h0041, tgt.wr_val[16'h0005])
    `CHECK("reg7_mask", 16'h0001, tgt.wr_val[16'h0007])
    `CHECK("reg12_mask", 16'h0001, tgt.wr_val[16'h000C])
    `CHECK("reg15_mask", 16'h0281, tgt.wr_val[16'h000F])
  endtask

  task automatic t_reset_rerun();
    @(posedge clk);
    nack_addr <= 1'b1;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    `CHECK("done_reset2", 1'b0, setup_done)
    rst_b <= 1'b1;
    base = tgt.n_writes;
    bus(1'b0, `CSL_OFF_CTRL, 32'h0);
    `CHECK("ctrl_reset", 32'h0, rd)
    wait_writes(base + 1);
    nack_addr <= 1'b0;
    bus(1'b0, `CSL_OFF_STATUS, 32'h0);
    `CHECK("nack_seen", 1'b1, rd[`CSL_ST_NACK])
    `CHECK("busy", 1'b1, rd[`CSL_ST_BUSY])
    bus(1'b1, `CSL_OFF_STATUS, 32'h0000_0004);
    bus(1'b0, `CSL_OFF_STATUS, 32'h0);
    `CHECK("nack_clear", 1'b0, rd[`CSL_ST_NACK])
    wait_writes(base + 9);
    `CHECK("reg6_p0", 16'h0005, tgt.wr_val[16'h0006])
    `CHECK("done_rerun", 1'b0, setup_done)
  endtask

  // ==========================================================================
  // Clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    nack_addr = 1'b0;
    t_power_up();
    t_profile1_run();
    t_restart_mask();
    t_reset_rerun();
    stop_test();
  end

  // The three loads take about 96k cycles; the limit leaves a small margin.
  initial begin
    #510000;
    num_errors++;
    stop_test();
  end
endmodule
